// ### bench/sat_pipe_model.sv
/*
 sat_pipe_model: pipeline side of the translation block; issues
 one-cycle translate and access-check requests, keeps the answers.
 Assumes the block answers one cycle after each request.
*/
`timescale 1ns/1ps
module sat_pipe_model (
   // clock
   input  wire logic        clk_sys,
   // translate request
   output logic             xl_req,
   output logic      [1:0]  xl_kind,
   output logic             xl_bp_base,
   output logic             xl_ovr_valid,
   output logic      [2:0]  xl_ovr_seg,
   output logic      [31:0] xl_offset,
   output logic             xl_byte_op,
   output logic             xl_size_pfx,
   output logic             xl_code32,
   // translate answer
   input  wire logic        xl_valid,
   input  wire logic [2:0]  xl_seg,
   input  wire logic [31:0] xl_lin_addr,
   input  wire logic [31:0] xl_phys_addr,
   input  wire logic [1:0]  xl_op_size,
   input  wire logic [3:0]  xl_byte_en,
   input  wire logic        xl_limit_fault,
   // access check
   output logic             chk_req,
   output logic      [3:0]  chk_class,
   output logic             chk_store,
   input  wire logic        chk_valid,
   input  wire logic        chk_allow
);
   // last answers seen
   logic        r_valid, r_fault, r_cv, r_ca;
   logic [2:0]  r_seg;
   logic [1:0]  r_size;
   logic [3:0]  r_be;
   logic [31:0] r_lin, r_phys;

   // quiet request lines from time zero
   initial
   begin
      {xl_req, xl_kind, xl_bp_base, xl_ovr_valid, xl_ovr_seg} = '0;
      {xl_offset, xl_byte_op, xl_size_pfx, xl_code32} = '0;
      {chk_req, chk_class, chk_store} = '0;
   end

   // one translate request; answer taken one cycle after it
   task automatic xlate(input logic [1:0] k, input logic bp, ov,
      input logic [2:0] os, input logic [31:0] off,
      input logic bo, pf, c32);
      @(posedge clk_sys);
      xl_req <= 1'b1;
      {xl_kind, xl_bp_base, xl_ovr_valid, xl_ovr_seg} <= {k, bp, ov, os};
      {xl_offset, xl_byte_op, xl_size_pfx, xl_code32} <= {off, bo, pf, c32};
      @(posedge clk_sys);
      xl_req <= 1'b0;
      xl_offset <= ~off; // offset does not hold once released
      @(posedge clk_sys);
      {r_valid, r_seg, r_lin} = {xl_valid, xl_seg, xl_lin_addr};
      {r_phys, r_size} = {xl_phys_addr, xl_op_size};
      {r_be, r_fault} = {xl_byte_en, xl_limit_fault};
   endtask : xlate

   // one access-check request
   task automatic sys_check(input logic [3:0] cls, input logic st);
      @(posedge clk_sys);
      {chk_req, chk_class, chk_store} <= {1'b1, cls, st};
      @(posedge clk_sys);
      {chk_req, chk_class, chk_store} <= {1'b0, ~cls, ~st};
      @(posedge clk_sys);
      {r_cv, r_ca} = {chk_valid, chk_allow};
   endtask : sys_check
endmodule : sat_pipe_model

// ### bench/tb.sv
/*
 tb: self-checking bench for sat_top; AHB-Lite master on the register
 port, pipeline side through sat_pipe_model.
 Assumes one slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
module tb;
   // clock, reset and register bus
   logic        clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   // pipeline side
   logic        xl_req, xl_bp_base, xl_ovr_valid, xl_byte_op;
   logic        xl_size_pfx, xl_code32, xl_valid, xl_limit_fault;
   logic        chk_req, chk_store, chk_valid, chk_allow;
   logic [1:0]  xl_kind, xl_op_size;
   logic [2:0]  xl_ovr_seg, xl_seg;
   logic [3:0]  xl_byte_en, chk_class;
   logic [31:0] xl_offset, xl_lin_addr, xl_phys_addr;
   int          num_errors, checks;

   // block and pipeline model
   sat_top #(.PAGE_ENTRIES(4)) dut (
      .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .xl_req, .xl_kind, .xl_bp_base, .xl_ovr_valid, .xl_ovr_seg,
      .xl_offset, .xl_byte_op, .xl_size_pfx, .xl_code32, .xl_valid,
      .xl_seg, .xl_lin_addr, .xl_phys_addr, .xl_op_size, .xl_byte_en,
      .xl_limit_fault, .chk_req, .chk_class, .chk_store, .chk_valid,
      .chk_allow);
   sat_pipe_model pipe (
      .clk_sys, .xl_req, .xl_kind, .xl_bp_base, .xl_ovr_valid,
      .xl_ovr_seg, .xl_offset, .xl_byte_op, .xl_size_pfx, .xl_code32,
      .xl_valid, .xl_seg, .xl_lin_addr, .xl_phys_addr, .xl_op_size,
      .xl_byte_en, .xl_limit_fault, .chk_req, .chk_class, .chk_store,
      .chk_valid, .chk_allow);

   // 125 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task final_report;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // next edge with hready high, bounded
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            num_errors++;
            final_report();
         end
         @(posedge clk_sys);
      end
   endtask : wait_rdy

   task automatic ahb_wr(input logic [31:0] a, d);
      {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, 1'b1};
      wait_rdy();
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      wait_rdy();
      hwdata <= ~d; // write data released
   endtask : ahb_wr

   task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
      {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, 1'b0};
      wait_rdy();
      {hsel, htrans} <= {1'b0, 2'h0};
      wait_rdy();
      d = hrdata;
   endtask : ahb_rd

   task automatic xl_exp(input logic [1:0] k, input logic bp, ov,
      input logic [2:0] os, input logic [31:0] off,
      input logic [2:0] s, input logic [31:0] lin, phys);
      pipe.xlate(k, bp, ov, os, off, 1'b0, 1'b0, 1'b1);
      check("xl_valid", pipe.r_valid, 32'h1); // answer
      check("xl_seg", pipe.r_seg, s); // segment
      check("xl_lin", pipe.r_lin, lin); // linear
      check("xl_phys", pipe.r_phys, phys); // physical
   endtask : xl_exp

   task automatic t_reset;
      ahb_rd(32'h0, rd);
      check("ctrl", rd, 32'h0); // real mode out of reset
      ahb_rd(32'h3c, rd);
      check("limit", rd, 32'hffff_ffff); // full 4 GB segment
      ahb_rd(32'h08, rd);
      check("unmapped", rd, 32'h0); // unmapped word reads zero
      check("hresp", hresp, 32'h0); // always okay
      $display("test reset done");
   endtask : t_reset

   // real mode: default segments, then every override
   task automatic t_real;
      logic [31:0] v;
      for (int i = 0; i < 6; i++)
         ahb_wr(32'h10 + 4 * i, 32'h100 * (i + 1));
      xl_exp(2'h1, 0, 0, 3'h0, 32'h10, 3'h3, 32'h4010, 32'h4010);
      xl_exp(2'h0, 0, 0, 3'h0, 32'hfff0, 3'h1, 32'h11ff0, 32'h11ff0);
      xl_exp(2'h2, 0, 0, 3'h0, 32'h4, 3'h2, 32'h3004, 32'h3004);
      xl_exp(2'h1, 1, 0, 3'h0, 32'h8, 3'h2, 32'h3008, 32'h3008);
      for (int i = 0; i < 6; i++)
      begin
         v = ((32'h100 * (i + 1)) << 4) + 32'h20;
         xl_exp(2'h1, 0, 1, i[2:0], 32'h20, i[2:0], v, v);
      end
      xl_exp(2'h3, 0, 1, 3'h5, 32'h20, 3'h0, 32'h1020, 32'h1020);
      $display("test real done");
   endtask : t_real

   // protected: base plus offset wraps, then a flat space
   task automatic t_prot;
      ahb_wr(32'h0, 32'h1); // reserved bits written as zero
      ahb_wr(32'h1c, 32'hffff_fff0);
      xl_exp(2'h1, 0, 0, 3'h0, 32'h20, 3'h3, 32'h10, 32'h10);
      for (int i = 0; i < 6; i++)
         ahb_wr(32'h10 + 4 * i, 32'h0);
      for (int i = 0; i < 6; i++)
         xl_exp(2'h1, 0, 1, i[2:0], 32'h8765_4320, i[2:0], 32'h8765_4320,
            32'h8765_4320); // flat space
      $display("test prot done");
   endtask : t_prot

   task automatic lim(input logic bo, input logic [31:0] off, input logic f);
      pipe.xlate(2'h1, 1'b0, 1'b0, 3'h0, off, bo, 1'b0, 1'b1);
      check("xl_limit_fault", pipe.r_fault, f); // segment size
   endtask : lim

   task automatic t_limit;
      ahb_wr(32'h3c, 32'h0);
      lim(1'b1, 32'h0, 1'b0);
      lim(1'b1, 32'h1, 1'b1);
      lim(1'b0, 32'h0, 1'b1);
      ahb_wr(32'h3c, 32'h3);
      lim(1'b0, 32'h0, 1'b0);
      lim(1'b0, 32'h1, 1'b1);
      ahb_wr(32'h3c, 32'hffff_ffff);
      lim(1'b0, 32'hffff_fffc, 1'b0);
      ahb_rd(32'h4, rd);
      check("status", rd, 32'h0000_0300); // three limit faults
      $display("test limit done");
   endtask : t_limit

   task automatic t_page;
      ahb_wr(32'h84, 32'habcd_e000);
      ahb_rd(32'h84, rd);
      check("frame", rd, 32'habcd_e000); // frame readback
      ahb_wr(32'h0, 32'h3);
      xl_exp(2'h1, 0, 0, 3'h0, 32'h1234, 3'h3, 32'h1234, 32'habcd_e234);
      xl_exp(2'h1, 0, 0, 3'h0, 32'h2567, 3'h3, 32'h2567, 32'h567);
      ahb_wr(32'h0, 32'h1);
      xl_exp(2'h1, 0, 0, 3'h0, 32'h1234, 3'h3, 32'h1234, 32'h1234);
      $display("test page done");
   endtask : t_page

   task automatic sz(input logic bo, pf, c32, input logic [1:0] o,
      input logic [1:0] s, input logic [3:0] be);
      pipe.xlate(2'h1, 1'b0, 1'b0, 3'h0, {30'h0, o}, bo, pf, c32);
      check("xl_op_size", pipe.r_size, s); // operand size
      check("xl_byte_en", pipe.r_be, be); // low byte lowest
   endtask : sz

   task automatic t_size;
      ahb_wr(32'h0, 32'h0);
      sz(1'b1, 1'b0, 1'b1, 2'h3, 2'h0, 4'h8);
      sz(1'b0, 1'b0, 1'b1, 2'h0, 2'h2, 4'hf);
      sz(1'b0, 1'b1, 1'b1, 2'h1, 2'h1, 4'h6);
      sz(1'b0, 1'b0, 1'b0, 2'h3, 2'h1, 4'h8);
      sz(1'b0, 1'b1, 1'b0, 2'h0, 2'h2, 4'hf);
      $display("test size done");
   endtask : t_size

   task automatic pv(input logic [31:0] c, input sat_pkg::sat_rclass_t k,
      input logic st, input logic ok);
      ahb_wr(32'h0, c);
      pipe.sys_check(k, st);
      check("chk_valid", pipe.r_cv, 32'h1); // answer
      check("chk_allow", pipe.r_ca, ok); // permission
   endtask : pv

   task automatic t_priv;
      pv(32'h01, sat_pkg::SAT_RC_CONTROL, 1'b0, 1'b1);
      pv(32'h31, sat_pkg::SAT_RC_CONTROL, 1'b0, 1'b0);
      pv(32'h31, sat_pkg::SAT_RC_CONTROL, 1'b1, 1'b0);
      pv(32'h31, sat_pkg::SAT_RC_DEBUG, 1'b1, 1'b0);
      pv(32'h31, sat_pkg::SAT_RC_TEST, 1'b0, 1'b0);
      pv(32'h31, sat_pkg::SAT_RC_GLOBAL_TBL, 1'b0, 1'b0);
      pv(32'h31, sat_pkg::SAT_RC_GLOBAL_TBL, 1'b1, 1'b1);
      pv(32'h31, sat_pkg::SAT_RC_INT_TBL, 1'b0, 1'b0);
      pv(32'h31, sat_pkg::SAT_RC_LOCAL_TBL, 1'b0, 1'b0);
      pv(32'h31, sat_pkg::SAT_RC_TASK, 1'b1, 1'b1);
      pv(32'h01, sat_pkg::SAT_RC_TASK, 1'b0, 1'b1);
      pv(32'h31, sat_pkg::SAT_RC_GENERAL, 1'b0, 1'b1);
      pv(32'hc5, sat_pkg::SAT_RC_FLAGS, 1'b0, 1'b1);
      pv(32'h05, sat_pkg::SAT_RC_FLAGS, 1'b1, 1'b0);
      $display("test priv done");
   endtask : t_priv

   // reset, then the scenarios in turn
   initial
   begin
      {resetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      num_errors = 0;
      checks = 0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_real();
      t_prot();
      t_limit();
      t_page();
      t_size();
      t_priv();
      final_report();
   end
endmodule : tb

// ### hw/sat_page_map.sv
/*
 sat_page_map: page frame table in flip-flops with a write port, a
 readback port and a lookup. Assumes synchronous writes from the
 register port.
*/
`timescale 1ns/1ps
module sat_page_map #(
   parameter int ENTRIES = 4
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // register access
   input  wire logic        wr_en,
   input  wire logic [$clog2(ENTRIES)-1:0] idx,
   input  wire logic [31:0] wr_data,
   output logic      [31:0] rd_data,
   // translation
   input  wire logic        enable,
   input  wire logic [31:0] lin_addr,
   output logic      [31:0] phys_addr
);
   localparam int IW = $clog2(ENTRIES);
   logic [31:sat_pkg::PAGE_BITS] frame      [ENTRIES];
   logic [31:sat_pkg::PAGE_BITS] next_frame [ENTRIES];
   logic [IW-1:0] look;

   // table update
   always_comb
   begin
      next_frame = frame;
      if (wr_en)
         next_frame[idx] = wr_data[31:sat_pkg::PAGE_BITS];
   end

   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < ENTRIES; i++)
         frame[i] <= !resetn ? '0 : next_frame[i];
   end

   // lookup keeps the byte within the page
   always_comb
   begin
      look = lin_addr[sat_pkg::PAGE_BITS +: IW];
      rd_data = {frame[idx], {sat_pkg::PAGE_BITS{1'b0}}};
      phys_addr = enable
         ? {frame[look], lin_addr[sat_pkg::PAGE_BITS-1:0]}
         : lin_addr;
   end
endmodule : sat_page_map

// ### hw/sat_pkg.sv
/*
 sat_pkg: shared constants and types for the segment address
 translation block. Assumes one 32-bit AHB-Lite register port.
*/
package sat_pkg;
   // register word offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_SEG_VAL = 8'h10; // six words
   localparam logic [7:0] OFS_SEG_LIM = 8'h30; // six words
   localparam logic [7:0] OFS_PAGE    = 8'h80; // page frame table
   // control register fields
   localparam int CTRL_PROT   = 0;
   localparam int CTRL_PAGING = 1;
   localparam int CTRL_V86    = 2;
   localparam int CTRL_RING   = 4; // two bits
   localparam int CTRL_IOPT   = 6; // two bits
   localparam logic [31:0] CTRL_MASK = 32'h0000_00f7;
   // status register fields
   localparam int STAT_FAULT  = 0;
   localparam int STAT_DENIED = 1;
   localparam int STAT_COUNT  = 8; // eight bits
   // reset values
   localparam logic [31:0] SEG_VAL_RST = 32'h0000_0000;
   localparam logic [31:0] SEG_LIM_RST = 32'hffff_ffff;
   // address forming and permission constants
   localparam int REAL_SHIFT  = 4;
   localparam int PAGE_BITS   = 12;
   localparam int NUM_SEGS    = 6;
   localparam logic [1:0] RING_TOP = 2'h0;
   localparam logic [1:0] IOPT_MAX = 2'h3;
   // segment register indexes
   typedef enum logic [2:0] {
      SAT_SEG_EXTRA_E = 3'h0, SAT_SEG_CODE = 3'h1, SAT_SEG_STACK = 3'h2,
      SAT_SEG_DEFAULT_DATA = 3'h3, SAT_SEG_EXTRA_F = 3'h4,
      SAT_SEG_EXTRA_G = 3'h5
   } sat_seg_t;
   // kinds of memory reference
   typedef enum logic [1:0] {
      SAT_REF_CODE = 2'h0, SAT_REF_DATA = 2'h1, SAT_REF_STACK = 2'h2,
      SAT_REF_STRDST = 2'h3
   } sat_ref_t;
   // operand sizes
   typedef enum logic [1:0] {
      SAT_SZ_BYTE = 2'h0, SAT_SZ_WORD = 2'h1, SAT_SZ_DWORD = 2'h2
   } sat_size_t;
   // system register classes for access checks
   typedef enum logic [3:0] {
      SAT_RC_GENERAL = 4'h0, SAT_RC_SEGMENT = 4'h1, SAT_RC_FLAGS = 4'h2,
      SAT_RC_CONTROL = 4'h3, SAT_RC_GLOBAL_TBL = 4'h4,
      SAT_RC_INT_TBL = 4'h5, SAT_RC_LOCAL_TBL = 4'h6,
      SAT_RC_TASK = 4'h7, SAT_RC_FPU = 4'h8, SAT_RC_DEBUG = 4'h9,
      SAT_RC_TEST = 4'ha
   } sat_rclass_t;
endpackage : sat_pkg

// ### hw/sat_seg_add.sv
/*
 sat_seg_add: forms a linear address from a segment value and an
 offset, and checks the segment limit. Assumes inputs are stable
 within the cycle; purely combinational.
*/
`timescale 1ns/1ps
module sat_seg_add (
   // segment and offset
   input  wire logic        prot,
   input  wire logic [31:0] seg_value,
   input  wire logic [31:0] seg_limit,
   input  wire logic [31:0] offset,
   input  wire logic [1:0]  last_byte,
   // result
   output logic      [31:0] lin_addr,
   output logic             over_limit
);
   logic [31:0] base;
   logic [32:0] last_ofs;

   // real mode shifts the selector, protected mode uses the base
   always_comb
   begin
      base = prot ? seg_value
                  : 32'(seg_value[15:0]) << sat_pkg::REAL_SHIFT;
      lin_addr = 32'(base + offset);
      last_ofs = {1'b0, offset} + {31'h0, last_byte};
      // limit runs from one byte to the full 4 GB range
      over_limit = prot && (last_ofs > {1'b0, seg_limit});
   end
endmodule : sat_seg_add

// ### hw/sat_top.sv
/*
 sat_top: segment address translation and system register access
 checking, with an AHB-Lite register port. Assumes one synchronous
 clock, the pipeline drives one request per cycle at most, and the
 bus master issues single word transfers.
*/
// Chosen here: the AHB-Lite interface to the registers and the address map.
// Functional notes
// - In real mode the selector is shifted left four bits and added to the offset.
// - In protected mode the segment's linear base is added to the offset.
// - The linear address is 32 bits and is the physical address while paging is off.
// - While paging is on the linear address goes through page translation.
// - Data uses the default data segment, or stack when based on bp; stack uses stack, fetches use code.
// - An override prefix picks the named segment for data, the only way to reach F and G; string destinations use E.
// - Segments may be sized from one byte up to four gigabytes.
// - Segment bases may overlap freely, all six may be zero for a flat space.
// - Multi-byte data is stored low byte first at the lowest address.
// - In protected mode privileged system register access needs ring zero.
// - In v86 mode push and pop of flags are gated by the I/O threshold.
// - Operands default to 32 or 16 bits by code size and a prefix swaps them.
`timescale 1ns/1ps
module sat_top #(
   parameter int PAGE_ENTRIES = 4
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // address request from the pipeline
   input  wire logic        xl_req,
   input  wire logic [1:0]  xl_kind,
   input  wire logic        xl_bp_base,
   input  wire logic        xl_ovr_valid,
   input  wire logic [2:0]  xl_ovr_seg,
   input  wire logic [31:0] xl_offset,
   input  wire logic        xl_byte_op,
   input  wire logic        xl_size_pfx,
   input  wire logic        xl_code32,
   // address result
   output logic             xl_valid,
   output logic      [2:0]  xl_seg,
   output logic      [31:0] xl_lin_addr,
   output logic      [31:0] xl_phys_addr,
   output logic      [1:0]  xl_op_size,
   output logic      [3:0]  xl_byte_en,
   output logic             xl_limit_fault,
   // system register access check
   input  wire logic        chk_req,
   input  wire logic [3:0]  chk_class,
   input  wire logic        chk_store,
   output logic             chk_valid,
   output logic             chk_allow
);
   localparam int IW = $clog2(PAGE_ENTRIES);
   // elaboration check on the page table size
   if (PAGE_ENTRIES < 2 || PAGE_ENTRIES > 32 ||
       (1 << IW) != PAGE_ENTRIES)
   begin : g_bad_entries
      $error("PAGE_ENTRIES must be a power of two from 2 to 32");
   end

   // register state
   logic [31:0] ctrl, next_ctrl, status, next_status;
   logic [31:0] seg_val [sat_pkg::NUM_SEGS];
   logic [31:0] seg_lim [sat_pkg::NUM_SEGS];
   logic [31:0] next_seg_val [sat_pkg::NUM_SEGS];
   logic [31:0] next_seg_lim [sat_pkg::NUM_SEGS];
   logic        wr_pend, next_wr_pend;
   logic [7:0]  wr_addr, next_wr_addr;
   logic [31:0] next_hrdata, page_rd;
   logic        page_wr;
   logic [IW-1:0] page_idx;
   logic [5:0]  rd_word, wr_word;
   logic        prot, v86;
   logic [1:0]  ring, iopt;

   assign prot = ctrl[sat_pkg::CTRL_PROT];
   assign v86  = ctrl[sat_pkg::CTRL_V86];
   assign ring = ctrl[sat_pkg::CTRL_RING +: 2];
   assign iopt = ctrl[sat_pkg::CTRL_IOPT +: 2];

   // bus decode: address phase captured, write done in data phase
   always_comb
   begin
      rd_word = haddr[7:2];
      wr_word = wr_addr[7:2];
      next_wr_pend = hready && hsel && htrans[1] && hwrite;
      next_wr_addr = next_wr_pend ? haddr[7:0] : wr_addr;
      next_hrdata = '0;                          // unmapped reads zero
      if (hready && hsel && htrans[1] && !hwrite)
      begin
         if (haddr[7:0] == sat_pkg::OFS_CTRL)
            next_hrdata = ctrl;
         else if (haddr[7:0] == sat_pkg::OFS_STATUS)
            next_hrdata = status;
         else if (haddr[7:0] >= sat_pkg::OFS_PAGE)
            next_hrdata = page_rd;
         for (int i = 0; i < sat_pkg::NUM_SEGS; i++)
         begin
            if (rd_word == 6'(sat_pkg::OFS_SEG_VAL[7:2] + i))
               next_hrdata = seg_val[i];
            if (rd_word == 6'(sat_pkg::OFS_SEG_LIM[7:2] + i))
               next_hrdata = seg_lim[i];
         end
      end
      page_wr = wr_pend && (wr_addr >= sat_pkg::OFS_PAGE);
      page_idx = page_wr ? wr_word[IW-1:0] : rd_word[IW-1:0];
   end

   // register writes; reserved control bits are kept at zero
   always_comb
   begin
      next_ctrl = ctrl;
      next_seg_val = seg_val;
      next_seg_lim = seg_lim;
      if (wr_pend && wr_addr == sat_pkg::OFS_CTRL)
         next_ctrl = hwdata & sat_pkg::CTRL_MASK;
      for (int i = 0; i < sat_pkg::NUM_SEGS; i++)
      begin
         if (wr_pend && wr_word == 6'(sat_pkg::OFS_SEG_VAL[7:2] + i))
            next_seg_val[i] = hwdata;            // bases may overlap
         if (wr_pend && wr_word == 6'(sat_pkg::OFS_SEG_LIM[7:2] + i))
            next_seg_lim[i] = hwdata;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         ctrl      <= '0;
         wr_pend   <= 1'b0;
         wr_addr   <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         for (int i = 0; i < sat_pkg::NUM_SEGS; i++)
         begin
            seg_val[i] <= sat_pkg::SEG_VAL_RST;    // flat by default
            seg_lim[i] <= sat_pkg::SEG_LIM_RST;
         end
      end
      else
      begin
         ctrl      <= next_ctrl;
         wr_pend   <= next_wr_pend;
         wr_addr   <= next_wr_addr;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;                       // zero wait states
         hresp     <= 1'b0;                       // always okay
         seg_val   <= next_seg_val;
         seg_lim   <= next_seg_lim;
      end
   end

   // segment selection, operand size and last byte of the operand
   logic [2:0]  sel_seg;
   logic [1:0]  op_size, last_byte;
   logic [31:0] lin, phys;
   logic        over;
   always_comb
   begin
      unique case (sat_pkg::sat_ref_t'(xl_kind))
         sat_pkg::SAT_REF_CODE:   sel_seg = sat_pkg::SAT_SEG_CODE;
         sat_pkg::SAT_REF_STACK:  sel_seg = sat_pkg::SAT_SEG_STACK;
         sat_pkg::SAT_REF_STRDST: sel_seg = sat_pkg::SAT_SEG_EXTRA_E;
         sat_pkg::SAT_REF_DATA:
            if (xl_ovr_valid && xl_ovr_seg < 3'(sat_pkg::NUM_SEGS))
               sel_seg = xl_ovr_seg;
            else if (xl_bp_base)
               sel_seg = sat_pkg::SAT_SEG_STACK;
            else
               sel_seg = sat_pkg::SAT_SEG_DEFAULT_DATA;
      endcase
      if (xl_byte_op)
         op_size = sat_pkg::SAT_SZ_BYTE;
      else if (xl_code32 ^ xl_size_pfx)
         op_size = sat_pkg::SAT_SZ_DWORD;
      else
         op_size = sat_pkg::SAT_SZ_WORD;
      last_byte = (op_size == sat_pkg::SAT_SZ_DWORD) ? 2'h3
                : (op_size == sat_pkg::SAT_SZ_WORD) ? 2'h1 : 2'h0;
   end

   sat_seg_add u_seg_add (
      .prot       (prot),
      .seg_value  (seg_val[sel_seg]),
      .seg_limit  (seg_lim[sel_seg]),
      .offset     (xl_offset),
      .last_byte  (last_byte),
      .lin_addr   (lin),
      .over_limit (over)
   );

   sat_page_map #(.ENTRIES(PAGE_ENTRIES)) u_page_map (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .wr_en     (page_wr),
      .idx       (page_idx),
      .wr_data   (hwdata),
      .rd_data   (page_rd),
      .enable    (ctrl[sat_pkg::CTRL_PAGING]),
      .lin_addr  (lin),
      .phys_addr (phys)
   );

   // system register permission by mode, ring and threshold
   logic allow;
   always_comb
   begin
      allow = 1'b1;
      unique case (sat_pkg::sat_rclass_t'(chk_class))
         sat_pkg::SAT_RC_FLAGS:
            allow = !v86 || (iopt == sat_pkg::IOPT_MAX);
         sat_pkg::SAT_RC_CONTROL:
            allow = v86 ? chk_store : (!prot || ring == sat_pkg::RING_TOP);
         sat_pkg::SAT_RC_GLOBAL_TBL, sat_pkg::SAT_RC_INT_TBL:
            allow = v86 ? chk_store
                  : (!prot || chk_store || ring == sat_pkg::RING_TOP);
         sat_pkg::SAT_RC_LOCAL_TBL, sat_pkg::SAT_RC_TASK:
            allow = prot && !v86 && (chk_store || ring == sat_pkg::RING_TOP);
         sat_pkg::SAT_RC_DEBUG, sat_pkg::SAT_RC_TEST:
            allow = !v86 && (!prot || ring == sat_pkg::RING_TOP);
         default:
            allow = 1'b1;
      endcase
   end

   // result registers and fault status
   always_comb
   begin
      next_status = status;
      if (xl_req)
      begin
         next_status[sat_pkg::STAT_FAULT] = over;
         if (over)
            next_status[sat_pkg::STAT_COUNT +: 8] =
               8'(status[sat_pkg::STAT_COUNT +: 8] + 8'h01);
      end
      if (chk_req)
         next_status[sat_pkg::STAT_DENIED] = !allow;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         status <= '0;
         xl_valid <= 1'b0;
         xl_seg <= '0;
         xl_lin_addr <= '0;
         xl_phys_addr <= '0;
         xl_op_size <= '0;
         xl_byte_en <= '0;
         xl_limit_fault <= 1'b0;
         chk_valid <= 1'b0;
         chk_allow <= 1'b0;
      end
      else
      begin
         status <= next_status;
         xl_valid <= xl_req;
         xl_seg <= sel_seg;
         xl_lin_addr <= lin;
         xl_phys_addr <= phys;
         xl_op_size <= op_size;
         // low byte sits at the lowest address lane
         xl_byte_en <= 4'(((5'h02 << last_byte) - 5'h01) << phys[1:0]);
         xl_limit_fault <= xl_req && over;
         chk_valid <= chk_req;
         chk_allow <= chk_req && allow;
      end
   end

   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [31:0] cs_real, data_base;
   assign cs_real = {12'h000, seg_val[1][15:0], 4'h0};
   assign data_base = seg_val[3];

   a_real_lin_addr: assert property (xl_req && !prot &&
      xl_kind == 2'h0 |=> xl_lin_addr == 32'($past(cs_real) +
      $past(xl_offset))) else $error("real mode address wrong");
   a_prot_lin_addr: assert property (xl_req && prot && !v86 &&
      xl_kind == 2'h1 && !xl_ovr_valid && !xl_bp_base |=>
      xl_lin_addr == 32'($past(data_base) + $past(xl_offset)))
      else $error("protected mode address wrong");
   a_phys_unpaged: assert property (xl_req &&
      !ctrl[sat_pkg::CTRL_PAGING] |=> xl_phys_addr == xl_lin_addr)
      else $error("unpaged address changed");
   a_page_offset: assert property (xl_req &&
      ctrl[sat_pkg::CTRL_PAGING] |=> xl_phys_addr[11:0] ==
      xl_lin_addr[11:0]) else $error("page offset lost");
   a_stack_seg: assert property (xl_req && xl_kind == 2'h2
      |=> xl_valid && xl_seg == 3'h2) else $error("stack segment wrong");
   a_override_seg: assert property (xl_req && xl_kind == 2'h1 &&
      xl_ovr_valid && xl_ovr_seg < 3'h6 |=> xl_seg == $past(xl_ovr_seg))
      else $error("override ignored");
   a_limit_fault: assert property (xl_req && prot &&
      xl_kind == 2'h1 && !xl_ovr_valid && !xl_bp_base &&
      xl_offset > seg_lim[3] |=> xl_limit_fault)
      else $error("limit fault missed");
   a_byte_lanes: assert property (xl_valid && xl_op_size == 2'h2
      && xl_phys_addr[1:0] == 2'h0 |-> xl_byte_en == 4'hf)
      else $error("dword lanes wrong");
   a_ring_check: assert property (chk_req && prot && !v86 &&
      chk_class == 4'h9 && ring != 2'h0 |=> chk_valid && !chk_allow)
      else $error("privileged access allowed");
   a_flags_v86: assert property (chk_req && v86 &&
      chk_class == 4'h2 |=> chk_allow == ($past(iopt) == 2'h3))
      else $error("flags gating wrong");
   a_op_size: assert property (xl_req && !xl_byte_op |=>
      xl_op_size == ($past(xl_code32 ^ xl_size_pfx) ? 2'h2 : 2'h1))
      else $error("operand size wrong");
   a_sum_wrap: assert property (xl_req && prot && xl_kind == 2'h1
      && !xl_ovr_valid && !xl_bp_base && seg_val[3] == 32'hffff_fff0 &&
      xl_offset == 32'h20 |=> xl_lin_addr == 32'h10) else $error("carry lost");

   c_paged: cover property (xl_req && ctrl[sat_pkg::CTRL_PAGING]);
   c_override: cover property (xl_req && xl_ovr_valid);
   c_denied: cover property (chk_valid && !chk_allow);
   c_bus_write: cover property (wr_pend ##2 wr_pend);
endmodule : sat_top
